// ==== bench/rid_decoder_sva.sv ====
/*
  Port checker of the instruction decoder.
  Assumes it is bound to the decoder with all watched ports connected.
*/
`default_nettype none
module rid_decoder_sva
(
  input wire logic                  i_sys_clk,
  input wire logic                  i_rstn,
  input wire logic [13:0]           i_instr,
  input wire logic                  i_skip_true,
  input wire rid_pkg::rid_ctrl_type o_ctrl,
  input wire logic                  o_flush_cycle,
  input wire logic                  o_fetch_next
);
  timeunit 1ns;
  timeprecision 1ps;
  import rid_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_take(logic [1:0] g);
    o_fetch_next && i_instr[13:12] == g;
  endsequence
  // The skip answer is judged at the fetch edge that closes the test's own cycle.
  // A word caught by a no-op cycle is discarded, so it is left out.
  sequence s_skip(logic t);
    o_fetch_next && i_instr[13:11] == 3'h3 ##1 !o_flush_cycle ##3 i_skip_true == t;
  endsequence
  sequence s_branch;
    s_take(2'h2) ##1 !o_flush_cycle;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_cycle_four: assert property (o_fetch_next |=> !o_fetch_next [*3] ##1 o_fetch_next)
    else $error("cycle length wrong");
  a_byte_fields: assert property (s_take(2'h0) |=> o_ctrl.group == GRP_BYTE
    && o_ctrl.reg_index == $past(i_instr[6:0]) && o_ctrl.result_target == $past(i_instr[7]))
    else $error("byte fields wrong");
  a_bit_pos: assert property (s_take(2'h1) |=> o_ctrl.group == GRP_BIT
    && o_ctrl.selected_position == $past(i_instr[9:7])) else $error("bit fields wrong");
  a_jump_const: assert property (s_take(2'h2) |=> o_ctrl.constant_operand == $past(i_instr[10:0])
    && o_ctrl.op == ($past(i_instr[11]) ? ALU_GOTO : ALU_CALL)) else $error("jump decode wrong");
  a_add_lit: assert property (o_fetch_next && i_instr[13:9] == 5'h1f |=> o_ctrl.op == ALU_ADDLW
    && {o_ctrl.wr_acc, o_ctrl.upd_c, o_ctrl.upd_dc, o_ctrl.upd_z} == (o_flush_cycle ? 4'h0 : 4'hf))
    else $error("add literal wrong");
  a_branch_flush: assert property (s_branch |-> ##4 o_flush_cycle [*4])
    else $error("branch flush wrong");
  a_flush_mask: assert property (o_flush_cycle |-> !(o_ctrl.wr_file || o_ctrl.wr_acc || o_ctrl.upd_c
    || o_ctrl.upd_dc || o_ctrl.upd_z || o_ctrl.is_sleep || o_ctrl.is_clrwdt))
    else $error("no-op cycle writes");
  a_skip_flush: assert property (s_skip(1'h1) |=> o_flush_cycle [*4])
    else $error("skip flush missing");
  a_skip_none: assert property (s_skip(1'h0) |=> !o_flush_cycle)
    else $error("false skip flushed");
endmodule // rid_decoder_sva
bind rid_decoder rid_decoder_sva chk_u (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_instr(i_instr),
  .i_skip_true(i_skip_true), .o_ctrl(o_ctrl), .o_flush_cycle(o_flush_cycle), .o_fetch_next(o_fetch_next));
`default_nettype wire

// ==== bench/rid_decoder_test.sv ====
/*
  Self-checking bench of the instruction decoder fed by the fetch model.
  Assumes package, decoder, fetch model and checker are compiled first.
*/
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module rid_decoder_test;
  timeunit 1ns;
  timeprecision 1ps;
  import rid_pkg::*;
  logic         clk = 1'h0;
  logic         rstn = 1'h0;
  logic [14:0]  wrd = 15'h0000;
  logic [13:0]  instr;
  logic         skip;
  rid_ctrl_type ctrl;
  logic         valid;
  logic         flush;
  logic         fetch;
  logic [1:0]   phase;
  int           n_fail = 0;
  int           n_compared = 0;
  always #4 clk = ~clk;
  rid_fetch_model mem_u (.i_sys_clk(clk), .i_rstn(rstn), .i_fetch(fetch), .i_word(wrd), .o_instr(instr),
    .o_skip_true(skip));
  rid_decoder dut_u (.i_sys_clk(clk), .i_rstn(rstn), .i_instr(instr), .i_skip_true(skip), .o_ctrl(ctrl),
    .o_exec_valid(valid), .o_flush_cycle(flush), .o_fetch_next(fetch), .o_phase(phase));
  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Stages a word for the next fetch edge and returns one step into its execute cycle.
  task automatic issue(input logic [13:0] w, input logic sk);
    for (int n = 0; n < 8 && phase !== 2'h2; n++)
      @(posedge clk) #1;
    @(posedge clk);
    wrd <= {sk, w};
    @(posedge clk);
    wrd <= 15'h0000;
    #1;
    `CHK("valid", 1'h1, valid)
  endtask
  task automatic t_byte_target();
    issue(14'h07ff, 1'h0);
    `CHK("file write", 2'h2, {ctrl.wr_file, ctrl.wr_acc})
    `CHK("index", 7'h7f, ctrl.reg_index)
    `CHK("pin source", 1'h1, ctrl.use_pins)
    issue(14'h0700, 1'h0);
    `CHK("acc write", 2'h1, {ctrl.wr_file, ctrl.wr_acc})
    `CHK("pin source", 1'h0, ctrl.use_pins)
    `CHK("index", 7'h00, ctrl.reg_index)
    `CHK("group", GRP_BYTE, ctrl.group)
    `CHK("plain flush", 1'h0, flush)
  endtask
  task automatic t_bit_select();
    for (int b = 0; b < 8; b++)
    begin
      issue(14'h1415 | 14'(b << 7), 1'h0);
      `CHK("bit", 3'(b), ctrl.selected_position)
      `CHK("group", GRP_BIT, ctrl.group)
      `CHK("bit pin source", 1'h1, ctrl.use_pins)
    end
  endtask
  task automatic t_add_literal();
    for (int x = 0; x < 2; x++)
    begin
      issue(14'h3ea5 | 14'(x << 8), 1'h0);
      `CHK("op", ALU_ADDLW, ctrl.op)
      `CHK("k", 8'ha5, ctrl.constant_operand[7:0])
      `CHK("flags", 4'hf, {ctrl.wr_acc, ctrl.upd_c, ctrl.upd_dc, ctrl.upd_z})
    end
  endtask
  task automatic t_branch();
    rid_op_type ops[2] = '{ALU_CALL, ALU_GOTO};
    for (int g = 0; g < 2; g++)
    begin
      issue(14'h25a3 | 14'(g << 11), 1'h0);
      `CHK("op", ops[g], ctrl.op)
      `CHK("target", 11'h5a3, ctrl.constant_operand)
      issue(g ? 14'h2fff : 14'h07ff, 1'h0);
      `CHK("flush", 1'h1, flush)
      `CHK("masked writes", 5'h00, {ctrl.wr_file, ctrl.wr_acc, ctrl.upd_c, ctrl.upd_dc, ctrl.upd_z})
      issue(14'h0000, 1'h0);
      `CHK("flush end", 1'h0, flush)
    end
  endtask
  task automatic t_control();
    issue(14'h0008, 1'h0);
    `CHK("return", ALU_RETURN, ctrl.op)
    issue(14'h0063, 1'h0);
    `CHK("return flush", 1'h1, flush)
    `CHK("masked sleep", 1'h0, ctrl.is_sleep)
    issue(14'h0063, 1'h0);
    `CHK("sleep", 1'h1, ctrl.is_sleep)
    `CHK("sleep flush", 1'h0, flush)
    issue(14'h0064, 1'h0);
    `CHK("clear watchdog", 1'h1, ctrl.is_clrwdt)
    issue(14'h0060, 1'h0);
    `CHK("nop ignored bits", 1'h0, ctrl.is_illegal)
    issue(14'h0001, 1'h0);
    `CHK("illegal", 1'h1, ctrl.is_illegal)
  endtask
  task automatic t_skip();
    for (int s = 1; s >= 0; s--)
    begin
      issue(14'h1805, 1'(s));
      issue(14'h0000, 1'h0);
      `CHK("skip flush", 1'(s), flush)
    end
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    t_byte_target();
    t_bit_select();
    t_add_literal();
    t_branch();
    t_skip();
    t_control();
    give_verdict();
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule // rid_decoder_test
`default_nettype wire

// ==== bench/rid_fetch_model.sv ====
/*
  Fetch side of the decoder: program word bus and the datapath's skip answer.
  Assumes the bench stages each word, its skip answer in bit 14, before the fetch edge.
*/
`default_nettype none
module rid_fetch_model
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_fetch,
  input  wire logic [14:0] i_word,
  output logic [13:0]      o_instr,
  output logic             o_skip_true
);
  timeunit 1ns;
  timeprecision 1ps;
  // Off the fetch edge the bus shows the inverse, so a late sample decodes junk.
  assign o_instr = i_fetch ? i_word[13:0] : ~i_word[13:0];
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_skip_true <= 1'h0;
    else if (i_fetch)
      o_skip_true <= i_word[14];
  end
endmodule // rid_fetch_model
`default_nettype wire

// ==== rtl/rid_cfg.svh ====
/*
  Constants of the 14-bit instruction decoder: field positions, group codes and timing counts.
  Assumes it is included by the decoder and phase counter modules by its bare name.
*/
// Function
// - each instruction is one 14-bit word split into opcode and operand fields.
// - byte operations: target 0 writes accumulator, 1 writes the indexed file register.
// - register index selects a file register from 0x00 to 0x7F.
// - bit operations choose one bit of the addressed 8-bit register.
// - literal operands are eight bits for data, eleven bits for jumps and calls.
// - ignored opcode bits never change behaviour.
// - one cycle per instruction; taken tests and branches take two, second a no-op.
// - one instruction cycle is exactly four clocks.
// - three groups recognised: byte, bit, literal and control, each its own layout.
// - self-modifying I/O operations read the pin levels, not the output latch.
// - add-literal adds constant to accumulator and updates carry, digit carry, zero.
`ifndef RID_CFG_SVH
`define RID_CFG_SVH

`define RID_WORD_W      14
`define RID_GRP_MSB     13
`define RID_GRP_LSB     12
`define RID_GRP_BYTE    2'h0
`define RID_GRP_BIT     2'h1
`define RID_GRP_BRANCH  2'h2
`define RID_GRP_LIT     2'h3
`define RID_SUB_MSB     11
`define RID_SUB_LSB     8
`define RID_DEST_POS    7
`define RID_FILE_MSB    6
`define RID_BITSEL_MSB  9
`define RID_BITSEL_LSB  7
`define RID_JUMP_POS    11
`define RID_PHASES      4
`define RID_PHASE_LAST  2'h3

`endif

// ==== rtl/rid_decoder.sv ====
/*
  Instruction decoder of a small 8-bit RISC core: splits each 14-bit word into fields,
  drives datapath controls for one instruction cycle and inserts the no-op second cycle.
  Assumes the fetch side presents the word before the cycle start and the datapath reports
  the skip condition by the end of the execute cycle.
*/
`default_nettype none
`include "rid_cfg.svh"
module rid_decoder
(
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_rstn,
  input  wire logic [13:0]           i_instr,
  input  wire logic                  i_skip_true,
  output rid_pkg::rid_ctrl_type      o_ctrl,
  output logic                       o_exec_valid,
  output logic                       o_flush_cycle,
  output logic                       o_fetch_next,
  output logic [1:0]                 o_phase
);
  import rid_pkg::*;

  logic         cycle_end;
  logic         flush;
  logic         next_flush;
  logic         pc_change;
  rid_ctrl_type next_ctrl;
  rid_ctrl_type exec_ctrl;

  rid_phase u_phase
  (
    .i_sys_clk   (i_sys_clk),
    .i_rstn      (i_rstn),
    .o_phase     (o_phase),
    .o_cycle_end (cycle_end)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Combinational decode of the fetched word.

  function automatic logic changes_pc(input rid_op_type op);
    changes_pc = (op == ALU_CALL) || (op == ALU_GOTO) || (op == ALU_RETURN) ||
                 (op == ALU_RETFIE) || (op == ALU_RETLW);
  endfunction

  function automatic logic is_skip(input rid_op_type op);
    is_skip = (op == ALU_DECSZ) || (op == ALU_INCSZ) || (op == ALU_BTFSC) || (op == ALU_BTFSS);
  endfunction

  // The added no-op cycle keeps the decoded fields visible for tracing, but every
  // write and side action is dropped so the discarded word cannot touch any state.
  function automatic rid_ctrl_type suppress_writes(input rid_ctrl_type c);
    suppress_writes           = c;
    suppress_writes.wr_file   = 1'b0;
    suppress_writes.wr_acc    = 1'b0;
    suppress_writes.upd_c     = 1'b0;
    suppress_writes.upd_dc    = 1'b0;
    suppress_writes.upd_z     = 1'b0;
    suppress_writes.is_sleep  = 1'b0;
    suppress_writes.is_clrwdt = 1'b0;
  endfunction

  always_comb
  begin
    logic [1:0] grp;
    logic [3:0] sub;
    logic       d;
    grp = i_instr[`RID_GRP_MSB:`RID_GRP_LSB];
    sub = i_instr[`RID_SUB_MSB:`RID_SUB_LSB];
    d   = i_instr[`RID_DEST_POS];
    next_ctrl = '0;
    next_ctrl.reg_index         = i_instr[`RID_FILE_MSB:0];
    next_ctrl.result_target     = d;
    next_ctrl.selected_position = i_instr[`RID_BITSEL_MSB:`RID_BITSEL_LSB];
    next_ctrl.op    = ALU_NOP;
    next_ctrl.group = GRP_LIT_CTRL;
    case (grp)
      `RID_GRP_BYTE:
      begin
        next_ctrl.group = GRP_BYTE;
        case (sub)
          4'h0:
          begin
            if (d)
              next_ctrl.op = ALU_MOVWF;
            else if (i_instr[6:0] == 7'h08)
              next_ctrl.op = ALU_RETURN;
            else if (i_instr[6:0] == 7'h09)
              next_ctrl.op = ALU_RETFIE;
            else if (i_instr[6:0] == 7'h63)
              next_ctrl.is_sleep = 1'b1;
            else if (i_instr[6:0] == 7'h64)
              next_ctrl.is_clrwdt = 1'b1;
            else if (i_instr[3:0] != 4'h0 || i_instr[4] != 1'b0)
              next_ctrl.is_illegal = 1'b1;
            // Bits 5 and 6 of the no-op are ignored.
          end
          4'h1: next_ctrl.op = ALU_CLR;
          4'h2: next_ctrl.op = ALU_SUB;
          4'h3: next_ctrl.op = ALU_DEC;
          4'h4: next_ctrl.op = ALU_IOR;
          4'h5: next_ctrl.op = ALU_AND;
          4'h6: next_ctrl.op = ALU_XOR;
          4'h7: next_ctrl.op = ALU_ADD;
          4'h8: next_ctrl.op = ALU_MOV;
          4'h9: next_ctrl.op = ALU_COM;
          4'ha: next_ctrl.op = ALU_INC;
          4'hb: next_ctrl.op = ALU_DECSZ;
          4'hc: next_ctrl.op = ALU_RRF;
          4'hd: next_ctrl.op = ALU_RLF;
          4'he: next_ctrl.op = ALU_SWAP;
          default: next_ctrl.op = ALU_INCSZ;
        endcase
        if (next_ctrl.op != ALU_NOP && next_ctrl.op != ALU_RETURN && next_ctrl.op != ALU_RETFIE)
        begin
          next_ctrl.wr_file = d;
          next_ctrl.wr_acc  = ~d;
          next_ctrl.use_pins = d;
        end
        next_ctrl.upd_z  = (sub inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha});
        next_ctrl.upd_c  = (sub inside {4'h2, 4'h7, 4'hc, 4'hd});
        next_ctrl.upd_dc = (sub inside {4'h2, 4'h7});
        if (next_ctrl.op == ALU_MOVWF)
          next_ctrl.use_pins = 1'b0;
      end
      `RID_GRP_BIT:
      begin
        next_ctrl.group = GRP_BIT;
        case (sub[3:2])
          2'h0: next_ctrl.op = ALU_BCF;
          2'h1: next_ctrl.op = ALU_BSF;
          2'h2: next_ctrl.op = ALU_BTFSC;
          default: next_ctrl.op = ALU_BTFSS;
        endcase
        next_ctrl.wr_file  = ~sub[3];
        next_ctrl.use_pins = ~sub[3];
      end
      `RID_GRP_BRANCH:
      begin
        next_ctrl.constant_operand = i_instr[10:0];
        next_ctrl.op = i_instr[`RID_JUMP_POS] ? ALU_GOTO : ALU_CALL;
      end
      default:
      begin
        next_ctrl.constant_operand = {3'h0, i_instr[7:0]};
        next_ctrl.wr_acc = 1'b1;
        casez (sub)
          4'b00??: next_ctrl.op = ALU_MOVLW;
          4'b01??: next_ctrl.op = ALU_RETLW;
          4'b1000: next_ctrl.op = ALU_IORLW;
          4'b1001: next_ctrl.op = ALU_ANDLW;
          4'b1010: next_ctrl.op = ALU_XORLW;
          4'b110?: next_ctrl.op = ALU_SUBLW;
          default: next_ctrl.op = ALU_ADDLW;
        endcase
        next_ctrl.upd_z  = (sub[3] == 1'b1);
        next_ctrl.upd_c  = (next_ctrl.op == ALU_SUBLW) || (next_ctrl.op == ALU_ADDLW);
        next_ctrl.upd_dc = next_ctrl.upd_c;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Execute register and the inserted second cycle.

  assign pc_change = changes_pc(o_ctrl.op);

  // A word that falls into the no-op cycle is discarded and never executed, so it
  // may not start a no-op cycle of its own, even when it is a branch or a skip.
  always_comb
  begin
    next_flush = 1'b0;
    if (o_exec_valid && !flush)
    begin
      if (pc_change)
        next_flush = 1'b1;
      else if (is_skip(o_ctrl.op) && i_skip_true)
        next_flush = 1'b1;
    end
  end

  // Masking ahead of the register keeps o_ctrl a plain flip-flop output and
  // lets the datapath use the write enables without looking at the flush flag.
  always_comb
  begin
    exec_ctrl = next_ctrl;
    if (next_flush)
      exec_ctrl = suppress_writes(next_ctrl);
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers of the execute stage.

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      flush <= 1'b0;
    else if (cycle_end)
      flush <= next_flush;
  end

  // The next word is latched only at a cycle boundary so controls stay steady four clocks.
  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_ctrl       <= '0;
      o_exec_valid <= 1'b0;
    end
    else if (cycle_end)
    begin
      o_ctrl       <= exec_ctrl;
      o_exec_valid <= 1'b1;
    end
  end

  // While flushing, the write enables in o_ctrl are held low; o_exec_valid stays high.
  assign o_flush_cycle = flush;
  assign o_fetch_next  = cycle_end;
endmodule // rid_decoder
`default_nettype wire

// ==== rtl/rid_phase.sv ====
/*
  Four-phase instruction cycle counter running on the core clock.
  Assumes the clock is the core oscillator; emits a pulse on the last phase of each instruction cycle.
*/
`default_nettype none
`include "rid_cfg.svh"
module rid_phase
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rstn,
  output logic [1:0]      o_phase,
  output logic            o_cycle_end
);
  import rid_pkg::*;

  always_ff @(posedge i_sys_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_phase <= 2'h0;
    else
      o_phase <= o_phase + 2'h1;
  end

  assign o_cycle_end = (o_phase == `RID_PHASE_LAST);
endmodule // rid_phase
`default_nettype wire

// ==== rtl/rid_pkg.sv ====
/*
  Types shared by the instruction decoder and its phase counter.
  Assumes the constants header sits on the include path.
*/
`default_nettype none
package rid_pkg;
  typedef enum logic [4:0] {
    ALU_NOP, ALU_MOVWF, ALU_CLR, ALU_SUB, ALU_DEC, ALU_IOR, ALU_AND, ALU_XOR, ALU_ADD,
    ALU_MOV, ALU_COM, ALU_INC, ALU_DECSZ, ALU_RRF, ALU_RLF, ALU_SWAP, ALU_INCSZ,
    ALU_BCF, ALU_BSF, ALU_BTFSC, ALU_BTFSS, ALU_MOVLW, ALU_RETLW, ALU_IORLW, ALU_ANDLW,
    ALU_XORLW, ALU_SUBLW, ALU_ADDLW, ALU_CALL, ALU_GOTO, ALU_RETURN, ALU_RETFIE
  } rid_op_type;

  typedef enum logic [1:0] {GRP_BYTE, GRP_BIT, GRP_LIT_CTRL} rid_group_type;

  typedef struct packed {
    rid_group_type group;
    rid_op_type    op;
    logic [6:0]    reg_index;
    logic          result_target;
    logic [2:0]    selected_position;
    logic [10:0]   constant_operand;
    logic          wr_file;
    logic          wr_acc;
    logic          upd_c;
    logic          upd_dc;
    logic          upd_z;
    logic          use_pins;
    logic          is_sleep;
    logic          is_clrwdt;
    logic          is_illegal;
  } rid_ctrl_type;
endpackage
`default_nettype wire
